// ===== hw/uipc_io_power.sv
// IO and power control register, pin routing and regulator select.
// Assumes register requests are decoded from the link port upstream,
// one request per cycle, with read data sampled one cycle later.
//
// What this block does
// - Reads at 39h-3Bh return register; write stores, set ORs, clear ANDs
// - Lane swap exchanges plus and minus pins, including serial routing
// - Audio speaker routing ignores the lane swap bit
// - Serial level field bits 3:2 picks UART regulator voltage, reset 01
// - Serial level applied when serial transmit enable asserts after bus
// - Audio mode forces the regulator to 3.3 V
// - Bits 4 and 5 connect 125K pull-ups on plus and minus lines
// - UART mode enables both charger pull-ups automatically
// - Bus level field bits 7:6 picks USB regulator voltage, reset 00
// - Bus level applies in synchronous, serial and low power modes
// - Synchronous mode reports session valid in the receive command
// - Non-synchronous modes signal interrupts on data line 3
// - Non-synchronous modes present linestate on data lines 0 and 1
// - Linestate available in receive command and debug register
// - Start bit launches measurement and clears itself on completion
// - Resistor code: 000 0R, 001 75R, 010 100K ... 101 float, 111 error
`timescale 1ns/1ns
module uipc_io_power (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire uipc_pkg::uipc_req_t req,
    output logic [7:0] rdData,
    // Operating mode and line status
    input wire uipc_pkg::uipc_mode_t mode,
    input wire logic serial_tx_enable,
    input wire logic session_valid,
    input wire logic line_state_bit0,
    input wire logic line_state_bit1,
    input wire logic intPending,
    input wire logic [2:0] analogRidCode,
    // Transceiver line roles
    input wire logic phyPlusOut,
    input wire logic phyMinusOut,
    input wire logic serialTxData,
    output logic plusPinOut,
    output logic minusPinOut,
    input wire logic plusPinIn,
    input wire logic minusPinIn,
    output logic phyPlusIn,
    output logic phyMinusIn,
    output logic serialRxData,
    // Audio routing
    input wire logic audioLeft,
    input wire logic audioRight,
    output logic speaker_left_pin,
    output logic speaker_right_mono_pin,
    // Analogue controls
    output logic charger_plus_line_resistor,
    output logic charger_minus_line_resistor,
    output uipc_pkg::uipc_level_t regLevel,
    // Link status byte
    output logic [7:0] rxCmdByte,
    output logic [3:0] asyncData
);
    import uipc_pkg::*;

    function automatic logic [7:0] apply_write(input logic [7:0] cur,
        input logic [7:0] data, input logic [1:0] op, input logic [7:0] msk);
        logic [7:0] res;
        res = cur;
        unique case (op)
            2'h1: res = data;
            2'h2: res = cur | data;
            2'h3: res = cur & ~data;
            default: res = cur;
        endcase
        apply_write = (res & msk) | (cur & ~msk);
    endfunction : apply_write

    logic [7:0] iopwr_ff;
    logic [7:0] rid_ff;
    logic [7:0] rdData_ff;
    logic serialActive_ff;
    logic [1:0] regLevel_ff;
    logic [7:0] nxt_iopwr;
    logic [7:0] nxt_rid;
    logic ridDone;
    logic [2:0] ridCode;

    // Operation decode: 1 write, 2 set, 3 clear
    wire [1:0] ioOp = !req.wrEn ? 2'h0 :
        (req.addr == ADDR_IOPWR_WRITE) ? 2'h1 :
        (req.addr == ADDR_IOPWR_SET) ? 2'h2 :
        (req.addr == ADDR_IOPWR_CLEAR) ? 2'h3 : 2'h0;
    wire [1:0] ridOp = !req.wrEn ? 2'h0 :
        (req.addr == ADDR_RID_WRITE) ? 2'h1 :
        (req.addr == ADDR_RID_SET) ? 2'h2 :
        (req.addr == ADDR_RID_CLEAR) ? 2'h3 : 2'h0;
    wire ioHit = (req.addr >= ADDR_IOPWR_WRITE) &&
        (req.addr <= ADDR_IOPWR_CLEAR);
    wire ridHit = (req.addr >= ADDR_RID_WRITE) &&
        (req.addr <= ADDR_RID_CLEAR);
    wire ridRead = req.rdEn && ridHit;

    assign nxt_iopwr = apply_write(iopwr_ff, req.wrData, ioOp,
        IOPWR_WR_MASK);

    // Done bit: set by completion wins over clear-on-read
    always_comb
    begin
        nxt_rid = apply_write(rid_ff, req.wrData, ridOp, RID_WR_MASK);
        if (ridRead)
            nxt_rid[POS_RID_DONE] = 1'b0;
        if (ridDone)
        begin
            nxt_rid[POS_RID_START] = 1'b0;
            nxt_rid[POS_RID_DONE] = 1'b1;
            nxt_rid[2:0] = ridCode;
        end
    end

    uipc_rid_meter u_meter (
        .clock(clock),
        .rst_n(rst_n),
        .startLvl(rid_ff[POS_RID_START]),
        .analogCode(analogRidCode),
        .doneStb(ridDone),
        .codeOut(ridCode)
    );

    wire laneSwap = iopwr_ff[POS_LANE_SWAP];
    wire [1:0] serialLvl = iopwr_ff[POS_SERIAL_LVL +: 2];
    wire [1:0] busLvl = iopwr_ff[POS_BUS_LVL +: 2];
    wire [1:0] lineState = {line_state_bit1, line_state_bit0};

    // Serial level latched in when transmit enable rises in UART mode
    wire serialEnter = mode.uartMode && serial_tx_enable && !serialActive_ff;
    wire [1:0] nxt_level = mode.audioMode ? LVL_3V3 :
        serialEnter ? serialLvl :
        (serialActive_ff && mode.uartMode) ? regLevel_ff :
        (mode.syncMode || mode.serialMode || mode.lowPowerMode) ? busLvl :
        regLevel_ff;

    wire [7:0] readMux = ioHit ? iopwr_ff :
        ridHit ? rid_ff :
        (req.addr == ADDR_DEBUG) ? {6'h00, lineState} : 8'h00;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            iopwr_ff <= IOPWR_RESET;
            rid_ff <= RID_RESET;
            rdData_ff <= 8'h00;
            serialActive_ff <= 1'b0;
            regLevel_ff <= LVL_3V3;
        end
        else
        begin
            iopwr_ff <= nxt_iopwr;
            rid_ff <= nxt_rid;
            rdData_ff <= req.rdEn ? readMux : rdData_ff;
            serialActive_ff <= mode.uartMode &&
                (serial_tx_enable || serialActive_ff);
            regLevel_ff <= nxt_level;
        end
    end

    assign rdData = rdData_ff;
    assign regLevel = uipc_level_t'(regLevel_ff);

    // Line role swap for transceiver and UART traffic
    wire plusDrive = mode.uartMode ? serialTxData : phyPlusOut;
    wire minusDrive = mode.uartMode ? 1'b1 : phyMinusOut;
    assign plusPinOut = laneSwap ? minusDrive : plusDrive;
    assign minusPinOut = laneSwap ? plusDrive : minusDrive;
    assign phyPlusIn = laneSwap ? minusPinIn : plusPinIn;
    assign phyMinusIn = laneSwap ? plusPinIn : minusPinIn;
    assign serialRxData = laneSwap ? plusPinIn : minusPinIn;

    // Speaker pins never follow the swap
    assign speaker_left_pin = mode.audioMode & audioLeft;
    assign speaker_right_mono_pin = mode.audioMode & audioRight;

    assign charger_plus_line_resistor = iopwr_ff[POS_PLUS_PULLUP] |
        mode.uartMode;
    assign charger_minus_line_resistor = iopwr_ff[POS_MINUS_PULLUP] |
        mode.uartMode;

    // Status byte: linestate in bits 1:0, session valid in bit 3, bit 2 zero
    assign rxCmdByte = {4'h0, session_valid, 1'b0,
        lineState};
    assign asyncData = mode.syncMode ? 4'h0 :
        {intPending, 1'b0, lineState};

endmodule : uipc_io_power

// ===== include/uipc_pkg.sv
// Package for the IO and power control register block.
// Assumes a ULPI-style register port decoded upstream into rd/wr strobes.
package uipc_pkg;

    // Register addresses
    localparam logic [5:0] ADDR_IOPWR_WRITE = 6'h39;
    localparam logic [5:0] ADDR_IOPWR_SET = 6'h3a;
    localparam logic [5:0] ADDR_IOPWR_CLEAR = 6'h3b;
    localparam logic [5:0] ADDR_RID_WRITE = 6'h36;
    localparam logic [5:0] ADDR_RID_SET = 6'h37;
    localparam logic [5:0] ADDR_RID_CLEAR = 6'h38;
    localparam logic [5:0] ADDR_DEBUG = 6'h15;

    // Field positions of the IO and power control register
    localparam int POS_LANE_SWAP = 1;
    localparam int POS_SERIAL_LVL = 2;
    localparam int POS_PLUS_PULLUP = 4;
    localparam int POS_MINUS_PULLUP = 5;
    localparam int POS_BUS_LVL = 6;
    localparam logic [7:0] IOPWR_WR_MASK = 8'hfe;
    localparam logic [7:0] IOPWR_RESET = 8'h04;

    // Resistor measurement register fields
    localparam int POS_RID_DONE = 3;
    localparam int POS_RID_START = 4;
    localparam logic [7:0] RID_WR_MASK = 8'h77;
    localparam logic [7:0] RID_RESET = 8'h00;

    // Measurement time, 282 us at 100 MHz
    localparam int MEASURE_TIME_US = 282;
    localparam int CLOCK_MHZ = 100;
    localparam int MEASURE_CYCLES = MEASURE_TIME_US * CLOCK_MHZ;

    // Resistor codes
    localparam logic [2:0] RID_ZERO = 3'h0;
    localparam logic [2:0] RID_75 = 3'h1;
    localparam logic [2:0] RID_100K = 3'h2;
    localparam logic [2:0] RID_200K = 3'h3;
    localparam logic [2:0] RID_440K = 3'h4;
    localparam logic [2:0] RID_FLOAT = 3'h5;
    localparam logic [2:0] RID_ERROR = 3'h7;

    // Regulator levels
    typedef enum logic [1:0] {
        LVL_3V3 = 2'h0,
        LVL_3V0 = 2'h1,
        LVL_2V75 = 2'h2,
        LVL_2V5 = 2'h3
    } uipc_level_t;

    // Register access request
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [5:0] addr;
        logic [7:0] wrData;
    } uipc_req_t;

    // Transceiver operating mode
    typedef struct packed {
        logic syncMode;
        logic serialMode;
        logic lowPowerMode;
        logic uartMode;
        logic audioMode;
    } uipc_mode_t;

endpackage : uipc_pkg

// ===== hw/uipc_rid_meter.sv
// ID resistor measurement timer and sampler.
// Assumes an analogue comparator supplies the resistor code during a run.
`timescale 1ns/1ns
module uipc_rid_meter #(
    parameter int MEASURE_CNT = uipc_pkg::MEASURE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic startLvl,
    input wire logic [2:0] analogCode,
    // Result
    output logic doneStb,
    output logic [2:0] codeOut
);
    import uipc_pkg::*;

    logic [15:0] count_ff;
    logic busy_ff;
    logic [2:0] code_ff;
    logic done_ff;
    wire lastCycle = busy_ff && (count_ff == 16'(MEASURE_CNT - 1));

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            count_ff <= 16'h0000;
            busy_ff <= 1'b0;
            code_ff <= RID_ZERO;
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= lastCycle;
            if (lastCycle)
            begin
                busy_ff <= 1'b0;
                count_ff <= 16'h0000;
                code_ff <= analogCode;
            end
            else if (busy_ff)
                count_ff <= count_ff + 16'h0001;
            else if (startLvl && !done_ff)
                busy_ff <= 1'b1;
        end
    end

    assign doneStb = done_ff;
    assign codeOut = code_ff;

endmodule : uipc_rid_meter

// ===== verif/uipc_link_model.sv
// Link-side register master for the IO and power block.
// Assumes tb_top calls its tasks; it drives only at falling edges.
`timescale 1ns/1ns
module uipc_link_model (
    // Clock
    input wire logic clock,
    // Register port
    output uipc_pkg::uipc_req_t req,
    input wire logic [7:0] rdData
);
    import uipc_pkg::*;
    initial req = '0;
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clock) req <= '{1'h1, 1'h0, a, d};
        @(negedge clock) req <= '0;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clock) req <= '{1'h0, 1'h1, a, 8'h00};
        @(negedge clock) req <= '0;
        @(negedge clock) d = rdData;
    endtask : rd
    // Charger test set-up: idle the lines, then pull-ups one by one
    task automatic chg;
        wr(6'h04, 8'h49);
        wr(ADDR_IOPWR_SET, 8'h10);
        wr(ADDR_IOPWR_SET, 8'h20);
    endtask : chg
    // Resistor measurement: start, poll for done, return the byte
    task automatic rid(output logic [7:0] d);
        wr(ADDR_RID_SET, 8'h10);
        d = 8'h00;
        for (int n = 0; n < 12000 && d[3] !== 1'h1; n++)
            rd(ADDR_RID_WRITE, d);
    endtask : rid
endmodule : uipc_link_model

// ===== verif/uipc_io_power_checker.sv
// Checker for the IO and power block.
// Assumes one clock with synchronous active-low reset.
`timescale 1ns/1ns
module uipc_io_power_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Watched ports
    input wire uipc_pkg::uipc_req_t req,
    input wire logic [7:0] rdData,
    input wire uipc_pkg::uipc_mode_t mode,
    input wire logic session_valid,
    input wire logic line_state_bit0,
    input wire logic line_state_bit1,
    input wire logic intPending,
    input wire logic audioLeft,
    input wire logic speaker_left_pin,
    input wire logic charger_plus_line_resistor,
    input wire logic charger_minus_line_resistor,
    input wire uipc_pkg::uipc_level_t regLevel,
    input wire logic [7:0] rxCmdByte,
    input wire logic [3:0] asyncData
);
    import uipc_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_wr(a);
        req.wrEn && req.addr == a;
    endsequence
    sequence s_rd;
        req.rdEn && req.addr >= ADDR_IOPWR_WRITE &&
        req.addr <= ADDR_IOPWR_CLEAR;
    endsequence
    AST_WRITE: assert property (
        s_wr(ADDR_IOPWR_WRITE) ##2 s_rd |=>
        rdData == ($past(req.wrData, 3) & IOPWR_WR_MASK))
        else $error("full write not stored");
    AST_SET: assert property (
        s_wr(ADDR_IOPWR_SET) ##2 s_rd |=> (rdData & $past(req.wrData, 3))
        == ($past(req.wrData, 3) & IOPWR_WR_MASK))
        else $error("set bits missing");
    AST_CLEAR: assert property (
        s_wr(ADDR_IOPWR_CLEAR) ##2 s_rd |=>
        (rdData & $past(req.wrData, 3)) == 8'h00)
        else $error("clear bits remain");
    AST_UART_PULL: assert property (mode.uartMode |->
        charger_plus_line_resistor && charger_minus_line_resistor)
        else $error("uart pull-ups off");
    AST_SPEAKER: assert property (
        speaker_left_pin == (mode.audioMode && audioLeft))
        else $error("speaker routing wrong");
    AST_AUDIO_LVL: assert property (
        mode.audioMode [*2] |-> regLevel == LVL_3V3)
        else $error("audio level not 3.3");
    AST_ASYNC: assert property (!mode.syncMode |->
        asyncData == {intPending, 1'h0, line_state_bit1, line_state_bit0})
        else $error("async data wrong");
    AST_RXCMD: assert property (mode.syncMode |->
        rxCmdByte[3] == session_valid &&
        rxCmdByte[1:0] == {line_state_bit1, line_state_bit0})
        else $error("receive command wrong");
endmodule : uipc_io_power_checker
bind uipc_io_power uipc_io_power_checker i_chk (.clock, .rst_n, .req,
    .rdData, .mode, .session_valid, .line_state_bit0, .line_state_bit1,
    .intPending, .audioLeft, .speaker_left_pin, .charger_plus_line_resistor,
    .charger_minus_line_resistor, .regLevel, .rxCmdByte, .asyncData);

// ===== verif/tb_top.sv
// Testbench for the IO and power block.
// Assumes the link model drives the register port.
`timescale 1ns/1ns
module tb_top;
    import uipc_pkg::*;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    uipc_req_t req;
    uipc_mode_t mode = '0;
    logic txEn = 0, sv = 0, ls0 = 0, ls1 = 0, intP = 0, pO = 0, mO = 0;
    logic pI = 0, mI = 0, aL = 0;
    logic [2:0] ridCode = RID_100K;
    logic [7:0] rdData, rxCmd;
    logic [3:0] asyncD;
    logic pPin, mPin, pIn, pMI, sRx, spL, spR, chP, chM;
    uipc_level_t regLevel;
    int err_count = 0;
    int checks = 0;
    uipc_link_model i_link (.clock, .req, .rdData);
    uipc_io_power i_dut (.clock, .rst_n, .req, .rdData, .mode,
        .serial_tx_enable(txEn), .session_valid(sv), .line_state_bit0(ls0),
        .line_state_bit1(ls1), .intPending(intP), .analogRidCode(ridCode),
        .phyPlusOut(pO), .phyMinusOut(mO), .serialTxData(1'h1),
        .plusPinOut(pPin), .minusPinOut(mPin), .plusPinIn(pI),
        .minusPinIn(mI), .phyPlusIn(pIn), .phyMinusIn(pMI),
        .serialRxData(sRx),
        .audioLeft(aL), .audioRight(1'h0), .speaker_left_pin(spL),
        .speaker_right_mono_pin(spR), .charger_plus_line_resistor(chP),
        .charger_minus_line_resistor(chM), .regLevel, .rxCmdByte(rxCmd),
        .asyncData(asyncD));
    always #5 clock = ~clock;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic t_regs;
        logic [7:0] d;
        i_link.rd(ADDR_IOPWR_WRITE, d);
        chk(d, 8'h04);
        i_link.wr(ADDR_IOPWR_WRITE, 8'hff);
        i_link.rd(ADDR_IOPWR_SET, d);
        chk(d, 8'hfe);
        i_link.wr(ADDR_IOPWR_CLEAR, 8'h31);
        i_link.rd(ADDR_IOPWR_CLEAR, d);
        chk(d, 8'hce);
        i_link.wr(ADDR_IOPWR_SET, 8'h11);
        i_link.rd(ADDR_IOPWR_WRITE, d);
        chk(d, 8'hde);
        i_link.rd(6'h20, d);
        chk(d, 8'h00);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_pins;
        i_link.wr(ADDR_IOPWR_WRITE, 8'h02);
        i_link.chg;
        mode.syncMode = 1'h1;
        {pO, mO, pI, mI, ls0, ls1, intP} = 7'h4f;
        @(negedge clock);
        chk({pPin, mPin, pIn, pMI, chP, chM}, 8'h1b);
        mode = '0;
        mode.uartMode = 1'h1;
        @(negedge clock);
        chk({sRx, chP, chM, asyncD}, 8'h3b);
        mode.audioMode = 1'h1;
        aL = 1'h1;
        @(negedge clock);
        chk({spL, spR}, 8'h02);
        $display("t_pins done");
    endtask : t_pins
    task automatic t_level;
        logic [7:0] d;
        mode = '0;
        mode.syncMode = 1'h1;
        sv = 1'h1;
        i_link.wr(ADDR_IOPWR_WRITE, 8'hc8);
        i_link.rd(ADDR_DEBUG, d);
        chk({regLevel, d[1:0], rxCmd[3:0]}, 8'hfb);
        mode = '0;
        mode.uartMode = 1'h1;
        txEn = 1'h1;
        repeat (2) @(negedge clock);
        chk({6'h0, regLevel}, {6'h0, LVL_2V75});
        mode.audioMode = 1'h1;
        repeat (2) @(negedge clock);
        chk({6'h0, regLevel}, {6'h0, LVL_3V3});
        rst_n = 1'h0;
        repeat (2) @(negedge clock);
        rst_n = 1'h1;
        {mode, txEn} = '0;
        i_link.rd(ADDR_IOPWR_WRITE, d);
        chk(d, 8'h04);
        $display("t_level done");
    endtask : t_level
    task automatic t_rid;
        logic [7:0] d;
        i_link.rid(d);
        chk(d, {5'h01, RID_100K});
        i_link.rd(ADDR_RID_CLEAR, d);
        chk(d, {5'h00, RID_100K});
        $display("t_rid done");
    endtask : t_rid
    task automatic test_done;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (16) @(negedge clock);
        rst_n = 1'h1;
        t_regs;
        t_pins;
        t_level;
        t_rid;
        test_done;
    end
    initial
    begin
        #1000000;
        err_count++;
        test_done;
    end
endmodule : tb_top
